// ===== design/adc_cfg_pkg.sv
// constants for the converter configuration register bank
// assumes a 16-bit register word behind an 8-bit serial address word
package adc_cfg_pkg;
    localparam int          ADDR_W  = 7;
    localparam int          DATA_W  = 16;
    localparam int          XFER_W  = 24;
    localparam logic [6:0]  REG_IF   = 7'h00;
    localparam logic [6:0]  REG_CORR = 7'h01;
    localparam logic [6:0]  REG_OVR  = 7'h02;
    localparam logic [6:0]  REG_RST  = 7'h03;
    localparam logic [6:0]  REG_SYNL = 7'h0e;
    localparam logic [6:0]  REG_SYNH = 7'h0f;
    localparam logic [6:0]  REG_TEMP = 7'h2b;
    localparam logic [6:0]  REG_SWR  = 7'h2c;
    localparam logic [6:0]  REG_SLP  = 7'h37;
    localparam logic [6:0]  REG_BIAS = 7'h38;
    localparam logic [6:0]  REG_DRV  = 7'h3a;
    localparam logic [6:0]  REG_PINS = 7'h66;
    // writable masks and reset values
    localparam logic [15:0] MSK_IF   = 16'hd000;
    localparam logic [15:0] MSK_CORR = 16'h800a;
    localparam logic [15:0] MSK_OVR  = 16'h0780;
    localparam logic [15:0] MSK_RST  = 16'h4b18;
    localparam logic [15:0] MSK_SYNL = 16'hfffc;
    localparam logic [15:0] MSK_SYNH = 16'hf070;
    localparam logic [15:0] MSK_SLP  = 16'hc000;
    localparam logic [15:0] MSK_BIAS = 16'hfff0;
    localparam logic [15:0] MSK_DRV  = 16'hfe1b;
    localparam logic [15:0] RST_OVR  = 16'h0780;
    localparam logic [15:0] RST_RST  = 16'h4b18;
    localparam logic [15:0] RST_SYNL = 16'haaa8;
    localparam logic [15:0] RST_SYNH = 16'ha000;
    localparam logic [15:0] RST_BIAS = 16'hffff;
    localparam logic [15:0] RST_DRV  = 16'h081b;
    localparam logic [15:0] RST_PINS = 16'hffff;
    localparam logic [15:0] FIX_BIAS = 16'h000f;
    localparam logic [15:0] SWR_KEY  = 16'hd2f0;
    // field positions
    localparam int B_WIRE4 = 15;
    localparam int B_DEC   = 14;
    localparam int B_PASS  = 12;
    localparam int B_ACOR  = 15;
    localparam int B_FMT   = 3;
    localparam int B_HOLD  = 14;
    localparam int B_FUSE  = 6;
    localparam int B_SYNB  = 5;
    localparam int B_SPIN  = 4;
    localparam int B_OCLK  = 4;
    localparam int B_SPOA  = 3;
    localparam int B_OVRB  = 1;
    localparam int B_SPOB  = 0;
    localparam int B_SYNO  = 13;
    localparam int OVR_LAT = 12;
    typedef enum logic [1:0] {
        SYNC_OFF     = 2'b00,
        SYNC_ONESHOT = 2'b01,
        SYNC_PINS    = 2'b10,
        SYNC_BAD     = 2'b11
    } sync_mode_t;
endpackage

// ===== design/adc_config_register_bank.sv
// serial configuration register bank of a single-channel converter
// assumes serial pins are asynchronous and sampled by clock_i; the
// serial clock is far slower than clock_i (bench period 160 ns)
// Summary of operation
// (RULE1) reg 0 bit 15: 0 shared data pin, 1 separate output pin
// (RULE2) reg 0 bit 14 enables by-two decimation filter
// (RULE3) reg 0 bit 12 picks high-pass, only with decimation enabled
// (RULE4) reg 1 bit 15 turns auto-correction loop on
// (RULE5) reg 1 bit 3: 0 two's complement, 1 offset binary
// (RULE6) host sets reg 1 bit 1 for best performance
// (RULE7) reg 2 bits 10-7 over-range threshold, reset all ones
// (RULE8) over-range flag rises 12 output clocks after crossing; code raises it 13 clocks after the crossing
// (RULE9) reg 3 bit 14 high holds correction, low starts loop
// (RULE10) host keeps reg 3 bits 11,9,8,4,3 at one
// (RULE11) regs E/F four-bit patterns choose sync source; code decodes only reg F bits 15-12, reg E is never decoded
// (RULE12) reg F bits 6-4 choose reference voltage or external
// (RULE13) reg 2B bits 8-0 read temperature, writes ignored
// (RULE14) key written to reg 2C resets all registers, self clears
// (RULE15) reg 37 bits 15-14 sleep mode, only while enable low
// (RULE16) reg 38 performance field all ones, bits 3-0 read one
// (RULE17) reg 38 bit 6 enables fuse bias
// (RULE18) reg 38 bits 5,4 enable sync and spare input buffers
// (RULE19) reg 3A drive current code with matching range bits
// (RULE20) reg 3A bits 10-9 choose output termination
// (RULE21) reg 3A bits 4,3,1,0 enable output buffers
// (RULE22) reg 66 enables each output pin pair, reset all ones
// (RULE23) transfer: 8-bit address word then 16-bit data word
// (RULE24) first serial edge after select falls takes read flag
// (RULE25) fixed-zero bits read back as zero
`timescale 1ns/1ps
`default_nettype none
module adc_config_register_bank
    import adc_cfg_pkg::*;
#(
    parameter int TEMP_W = 9
) (
    input  wire logic              clock_i,
    input  wire logic              sys_rst_i,
    input  wire logic              reset_pin_n_i,
    input  wire logic              serial_select_n_i,
    input  wire logic              serial_clk_i,
    input  wire logic              serial_data_i,
    output logic                   serial_data_o,
    output logic                   serial_data_oe_o,
    output logic                   serial_out_pin_o,
    output logic                   serial_out_pin_oe_o,
    input  wire logic              chip_enable_i,
    input  wire logic [TEMP_W-1:0] temp_value_i,
    input  wire logic [3:0]        level_i,
    output logic                   overload_flag_o,
    output logic                   decim_on_o,
    output logic                   filter_pass_sel_o,
    output logic                   autocorrect_on_o,
    output logic                   offset_binary_o,
    output logic                   perf_setting_one_o,
    output logic [3:0]             ovr_threshold_o,
    output logic                   correction_hold_restart_o,
    output logic [1:0]             sync_mode_o,
    output logic [2:0]             ref_select_o,
    output logic                   ref_external_o,
    output logic [1:0]             sleep_mode_o,
    output logic                   fuse_bias_on_o,
    output logic                   sync_buffer_on_o,
    output logic                   spare_input_buffer_on_o,
    output logic [2:0]             drive_current_o,
    output logic [1:0]             driver_range_sel_o,
    output logic [1:0]             termination_o,
    output logic                   out_clock_buffer_on_o,
    output logic                   spare_output_buffer_on_a_o,
    output logic                   overload_buffer_on_o,
    output logic                   spare_output_buffer_on_b_o,
    output logic [15:0]            pin_enables_o
);
    // two-flop synchronisers; stage one read only by stage two
    logic [4:0] sync_a;
    logic [4:0] sync_b;
    logic       clk_d;
    logic       sel_d;
    always_ff @(posedge clock_i) begin
        sync_a <= {reset_pin_n_i, serial_select_n_i, serial_clk_i,
                   serial_data_i, chip_enable_i};
        sync_b <= sync_a;
        clk_d  <= sync_b[2];
        sel_d  <= sync_b[3];
    end
    wire logic rstpin_n = sync_b[4];
    wire logic sel_n    = sync_b[3];
    wire logic sclk     = sync_b[2];
    wire logic sdata    = sync_b[1];
    wire logic enable   = sync_b[0];
    wire logic rise     = sclk & ~clk_d;
    wire logic fall     = ~sclk & clk_d;
    wire logic sel_fall = ~sel_n & sel_d;

    // registers
    logic [15:0] r_if, r_corr, r_ovr, r_rst, r_synl, r_synh;
    logic [15:0] r_slp, r_bias, r_drv, r_pins;
    logic [4:0]  bitcnt;
    logic [23:0] shreg;
    logic        rd_req;
    logic [15:0] rd_word;
    logic        wr_stb;
    logic [15:0] shout;
    logic        driving;

    // register read mux, fixed bits shown
    function automatic logic [15:0] read_reg(input logic [6:0] a);
        logic [15:0] v;
        v = 16'h0000;
        unique case (a)
            REG_IF:   v = r_if;
            REG_CORR: v = r_corr;
            REG_OVR:  v = r_ovr;
            REG_RST:  v = r_rst;
            REG_SYNL: v = r_synl;
            REG_SYNH: v = r_synh;
            REG_TEMP: v = 16'(temp_value_i); // RULE13
            REG_SLP:  v = r_slp;
            REG_BIAS: v = r_bias | FIX_BIAS; // RULE16
            REG_DRV:  v = r_drv;
            REG_PINS: v = r_pins;
            default:  v = 16'h0000; // RULE25
        endcase
        return v;
    endfunction

    // serial shifter: bit counter restarts on select fall
    always_ff @(posedge clock_i) begin
        wr_stb <= 1'b0;
        if (sys_rst_i || sel_n) begin
            bitcnt <= 5'h00;
            rd_req <= 1'b0;
        end else if (rise && bitcnt < 5'(XFER_W)) begin
            shreg  <= {shreg[22:0], sdata}; // RULE23
            bitcnt <= bitcnt + 5'h01;
            if (bitcnt == 5'h00)
                rd_req <= sdata; // RULE24
            if (bitcnt == 5'(XFER_W - 1) && !rd_req)
                wr_stb <= 1'b1;
        end
        if (sel_fall)
            bitcnt <= 5'h00;
    end
    wire logic [6:0]  wa = shreg[22:16];
    wire logic [15:0] wd = shreg[15:0];

    // read data: loaded after the address word, shifted on falling edge
    always_ff @(posedge clock_i) begin
        if (sys_rst_i || sel_n) begin
            shout   <= 16'h0000;
            driving <= 1'b0;
        end else if (rd_req && bitcnt == 5'h08 && !driving) begin
            shout   <= read_reg(shreg[6:0]);
            driving <= 1'b1;
        end else if (driving && fall && bitcnt > 5'h08) begin
            shout <= {shout[14:0], 1'b0};
        end
    end
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            serial_data_o       <= 1'b0;
            serial_data_oe_o    <= 1'b0;
            serial_out_pin_o    <= 1'b0;
            serial_out_pin_oe_o <= 1'b0;
        end else begin
            serial_data_o       <= shout[15];
            serial_out_pin_o    <= shout[15];
            serial_data_oe_o    <= driving & ~r_if[B_WIRE4]; // RULE1
            serial_out_pin_oe_o <= driving & r_if[B_WIRE4]; // RULE1
        end
    end

    // register writes; key or reset pin restores defaults
    wire logic swr = wr_stb && wa == REG_SWR && wd == SWR_KEY; // RULE14
    always_ff @(posedge clock_i) begin
        if (sys_rst_i || !rstpin_n || swr) begin
            r_if   <= 16'h0000;
            r_corr <= 16'h0000;
            r_ovr  <= RST_OVR; // RULE7
            r_rst  <= RST_RST; // RULE9
            r_synl <= RST_SYNL; // RULE11
            r_synh <= RST_SYNH;
            r_slp  <= 16'h0000;
            r_bias <= RST_BIAS; // RULE16
            r_drv  <= RST_DRV;
            r_pins <= RST_PINS; // RULE22
        end else if (wr_stb) begin
            unique case (wa)
                REG_IF:   r_if   <= wd & MSK_IF;
                REG_CORR: r_corr <= wd & MSK_CORR;
                REG_OVR:  r_ovr  <= wd & MSK_OVR;
                REG_RST:  r_rst  <= wd & MSK_RST;
                REG_SYNL: r_synl <= wd & MSK_SYNL;
                REG_SYNH: r_synh <= wd & MSK_SYNH;
                REG_SLP:  r_slp  <= wd & MSK_SLP;
                REG_BIAS: r_bias <= wd & MSK_BIAS;
                REG_DRV:  r_drv  <= wd & MSK_DRV;
                REG_PINS: r_pins <= wd;
                default:  ; // key register holds nothing
            endcase
        end
    end

    // sync mode from pattern in high nibble of reg F
    function automatic logic [1:0] sync_dec(input logic [3:0] p);
        unique case (p)
            4'h0:    return SYNC_OFF;
            4'h5:    return SYNC_ONESHOT;
            4'ha:    return SYNC_PINS;
            default: return SYNC_BAD;
        endcase
    endfunction

    // over-range pipe, 13 clocks from crossing to flag
    logic [OVR_LAT-1:0] ovr_pipe;
    always_ff @(posedge clock_i) begin
        if (sys_rst_i)
            ovr_pipe <= '0;
        else
            ovr_pipe <= {ovr_pipe[OVR_LAT-2:0],
                         level_i > r_ovr[10:7]}; // RULE8
    end

    // decoded control outputs, all registered
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            overload_flag_o            <= 1'b0;
            decim_on_o                 <= 1'b0;
            filter_pass_sel_o          <= 1'b0;
            autocorrect_on_o           <= 1'b0;
            offset_binary_o            <= 1'b0;
            perf_setting_one_o         <= 1'b0;
            ovr_threshold_o            <= 4'hf;
            correction_hold_restart_o  <= 1'b1;
            sync_mode_o                <= SYNC_PINS;
            ref_select_o               <= 3'h0;
            ref_external_o             <= 1'b0;
            sleep_mode_o               <= 2'h0;
            fuse_bias_on_o             <= 1'b1;
            sync_buffer_on_o           <= 1'b1;
            spare_input_buffer_on_o    <= 1'b1;
            drive_current_o            <= 3'h0;
            driver_range_sel_o         <= 2'h1;
            termination_o              <= 2'h0;
            out_clock_buffer_on_o      <= 1'b1;
            spare_output_buffer_on_a_o <= 1'b1;
            overload_buffer_on_o       <= 1'b1;
            spare_output_buffer_on_b_o <= 1'b1;
            pin_enables_o              <= 16'hffff;
        end else begin
            overload_flag_o    <= ovr_pipe[OVR_LAT-1]; // RULE8
            decim_on_o         <= r_if[B_DEC]; // RULE2
            // pass selection ignored without decimation
            filter_pass_sel_o  <= r_if[B_DEC] & r_if[B_PASS]; // RULE3
            autocorrect_on_o   <= r_corr[B_ACOR]; // RULE4
            offset_binary_o    <= r_corr[B_FMT]; // RULE5
            perf_setting_one_o <= r_corr[1];
            ovr_threshold_o    <= r_ovr[10:7]; // RULE7
            correction_hold_restart_o <= r_rst[B_HOLD]; // RULE9
            sync_mode_o        <= sync_dec(r_synh[15:12]); // RULE11
            ref_select_o       <= r_synh[6:4]; // RULE12
            ref_external_o     <= r_synh[6:4] > 3'h4; // RULE12
            // sleep only takes hold while enable pin low
            sleep_mode_o <= enable ? 2'h0 : r_slp[15:14]; // RULE15
            fuse_bias_on_o          <= r_bias[B_FUSE]; // RULE17
            sync_buffer_on_o        <= r_bias[B_SYNB]; // RULE18
            spare_input_buffer_on_o <= r_bias[B_SPIN]; // RULE18
            drive_current_o         <= r_drv[15:13]; // RULE19
            driver_range_sel_o      <= r_drv[12:11]; // RULE19
            termination_o           <= r_drv[10:9]; // RULE20
            out_clock_buffer_on_o      <= r_drv[B_OCLK]; // RULE21
            spare_output_buffer_on_a_o <= r_drv[B_SPOA]; // RULE21
            overload_buffer_on_o       <= r_drv[B_OVRB]; // RULE21
            spare_output_buffer_on_b_o <= r_drv[B_SPOB]; // RULE21
            pin_enables_o              <= r_pins; // RULE22
        end
    end

    // checks
    ovr_latency_a: assert property (@(posedge clock_i)
        disable iff (sys_rst_i) ovr_pipe[0] |-> ##12 overload_flag_o) // RULE8
        else $error("overload flag latency wrong");
    pass_gate_a: assert property (@(posedge clock_i)
        disable iff (sys_rst_i) filter_pass_sel_o |-> $past(r_if[B_DEC]))
        else $error("pass selection without decimation"); // RULE3
    swreset_a: assert property (@(posedge clock_i)
        disable iff (sys_rst_i) swr |=> r_ovr == RST_OVR && r_pins == RST_PINS)
        else $error("software reset missed"); // RULE14
    oe_excl_a: assert property (@(posedge clock_i)
        disable iff (sys_rst_i) !(serial_data_oe_o && serial_out_pin_oe_o))
        else $error("both data pins driven"); // RULE1
    sleep_gate_a: assert property (@(posedge clock_i)
        disable iff (sys_rst_i) $past(enable) |-> sleep_mode_o == 2'h0)
        else $error("sleep while enabled"); // RULE15
    bias_low_a: assert property (@(posedge clock_i)
        disable iff (sys_rst_i)
        (read_reg(REG_BIAS) & FIX_BIAS) == FIX_BIAS)
        else $error("bias register low bits not one"); // RULE16
    zero_bits_a: assert property (@(posedge clock_i)
        disable iff (sys_rst_i) (r_if & ~MSK_IF) == 16'h0000)
        else $error("fixed zero bit set"); // RULE25
    ref_ext_a: assert property (@(posedge clock_i)
        disable iff (sys_rst_i)
        ref_external_o |-> ref_select_o > 3'h4)
        else $error("external reference flag wrong"); // RULE12
    cov_write_c: cover property (@(posedge clock_i) wr_stb);
    cov_read_c: cover property (@(posedge clock_i) driving);
    cov_swr_c: cover property (@(posedge clock_i) swr);
    cov_ovr_c: cover property (@(posedge clock_i) overload_flag_o);
endmodule
`default_nettype wire

// ===== bench/adc_cfg_host_model.sv
// host controller model driving the serial configuration link
// assumes clock_i is the bench clock; one serial period is 16 cycles
`timescale 1ns/1ps
`default_nettype none
module adc_cfg_host_model
    import adc_cfg_pkg::*;
(
    input  wire logic clock_i,
    output logic      serial_select_n_o,
    output logic      serial_clk_o,
    output logic      serial_data_o,
    input  wire logic dev_data_i,
    input  wire logic dev_data_oe_i,
    input  wire logic dev_out_pin_i,
    input  wire logic dev_out_oe_i
);
    logic host_bit = 1'b0;
    logic host_drive = 1'b1;
    logic four_wire = 1'b0;
    initial serial_select_n_o = 1'b1;
    initial serial_clk_o = 1'b0;
    // released wire shows the inverted last bit, never a stale copy
    assign serial_data_o = host_drive ? host_bit :
                           dev_data_oe_i ? dev_data_i : ~host_bit;
    // one frame; serial clock stands still outside it
    task automatic xfer(input logic rd, input logic [6:0] adr,
                        input logic [15:0] wd, output logic [15:0] rdat);
        logic [23:0] frame;
        frame = {rd, adr, wd};
        rdat = 16'h0000;
        @(posedge clock_i);
        serial_select_n_o <= 1'b0;
        for (int i = 0; i < 24; i++) begin
            repeat (8) @(posedge clock_i);
            serial_clk_o <= 1'b0;
            host_drive <= !(rd && i >= 8);
            host_bit <= frame[23-i];
            repeat (8) @(posedge clock_i);
            serial_clk_o <= 1'b1;
            if (rd && i >= 8) begin
                // undriven dedicated pin reads inverted, so a late oe shows
                rdat[23-i] = four_wire ? (dev_out_oe_i ? dev_out_pin_i :
                             ~dev_out_pin_i) : serial_data_o;
            end
        end
        repeat (8) @(posedge clock_i);
        serial_clk_o <= 1'b0;
        repeat (4) @(posedge clock_i);
        serial_select_n_o <= 1'b1;
        host_drive <= 1'b1;
        repeat (16) @(posedge clock_i);
        // follow the pin style the device now answers on
        if (!rd && adr == REG_IF) four_wire = wd[B_WIRE4];
        if (!rd && adr == REG_SWR && wd == SWR_KEY) four_wire = 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== bench/adc_config_register_bank_tb.sv
// self-checking bench for the configuration register bank
// assumes the host model owns the serial link; 100 MHz clock
`timescale 1ns/1ps
`default_nettype none
module adc_config_register_bank_tb;
    import adc_cfg_pkg::*;
    logic        clock_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        reset_pin_n_i = 1'b1;
    logic        chip_enable_i = 1'b1;
    logic [8:0]  temp_value_i = 9'h1a5;
    logic [3:0]  level_i = 4'h0;
    logic        sel_n, sclk, sdin, sd_o, sd_oe, sp_o, ovf, dec, pas;
    logic        acor, fmt, perf1, hold, refx, fuse, synb, spin, oclk;
    logic        spoa, obuf, spob, b, spoe;
    logic [3:0]  thr;
    logic [1:0]  syncm, slp, rng, term;
    logic [2:0]  refs, drv;
    logic [15:0] pins, rdat;
    int          err_total = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    // address, writable bits, reset value, bits the host keeps set
    logic [6:0]  addrs [10] = '{REG_IF, REG_CORR, REG_OVR, REG_RST,
        REG_SYNL, REG_SYNH, REG_SLP, REG_BIAS, REG_DRV, REG_PINS};
    logic [15:0] msks [10] = '{MSK_IF, MSK_CORR, MSK_OVR, MSK_RST,
        MSK_SYNL, MSK_SYNH, MSK_SLP, MSK_BIAS, MSK_DRV, 16'hffff};
    logic [15:0] rsts [10] = '{16'h0000, 16'h0000, RST_OVR, RST_RST,
        RST_SYNL, RST_SYNH, 16'h0000, RST_BIAS, RST_DRV, RST_PINS};
    logic [15:0] keeps [10] = '{16'h0000, 16'h0002, 16'h0000, 16'h0b18,
        16'h0000, 16'h0000, 16'h0000, 16'hff80, 16'h0800, 16'h0000};
    logic [3:0]  pats [4] = '{4'h0, 4'h5, 4'ha, 4'hf};

    always #5 clock_i = ~clock_i;

    adc_cfg_host_model adc_cfg_host_model_inst (
        .clock_i, .serial_select_n_o(sel_n), .serial_clk_o(sclk),
        .serial_data_o(sdin), .dev_data_i(sd_o), .dev_data_oe_i(sd_oe),
        .dev_out_pin_i(sp_o), .dev_out_oe_i(spoe)
    );

    adc_config_register_bank adc_config_register_bank_inst (
        .clock_i, .sys_rst_i, .reset_pin_n_i, .chip_enable_i,
        .temp_value_i, .level_i, .serial_select_n_i(sel_n),
        .serial_clk_i(sclk), .serial_data_i(sdin), .serial_data_o(sd_o),
        .serial_data_oe_o(sd_oe), .serial_out_pin_o(sp_o),
        .serial_out_pin_oe_o(spoe), .overload_flag_o(ovf),
        .decim_on_o(dec), .filter_pass_sel_o(pas), .autocorrect_on_o(acor),
        .offset_binary_o(fmt), .perf_setting_one_o(perf1),
        .ovr_threshold_o(thr), .correction_hold_restart_o(hold),
        .sync_mode_o(syncm), .ref_select_o(refs), .ref_external_o(refx),
        .sleep_mode_o(slp), .fuse_bias_on_o(fuse),
        .sync_buffer_on_o(synb), .spare_input_buffer_on_o(spin),
        .drive_current_o(drv), .driver_range_sel_o(rng),
        .termination_o(term), .out_clock_buffer_on_o(oclk),
        .spare_output_buffer_on_a_o(spoa), .overload_buffer_on_o(obuf),
        .spare_output_buffer_on_b_o(spob), .pin_enables_o(pins)
    );

    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        adc_cfg_host_model_inst.xfer(1'b0, a, d, rdat);
    endtask

    task automatic rd_chk(input logic [6:0] a, input logic [15:0] e);
        logic [15:0] r;
        adc_cfg_host_model_inst.xfer(1'b1, a, 16'h0000, r);
        check(r, e);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // hang guard; a full run needs roughly 30000 cycles
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 60000) begin
            err_total++;
            $display("[ERR] %0t run did not complete", $time);
            tally_and_finish();
        end
    end

    initial begin
        repeat (4) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        // reset values of the table and of the field decodes
        for (int i = 0; i < 10; i++) rd_chk(addrs[i], rsts[i]);
        rd_chk(REG_TEMP, 16'h01a5);
        check({thr, hold, syncm, rng, pins},
              {4'hf, 1'b1, 2'd2, 2'd1, 16'hffff});
        // all ones then all zeros; zero pass brings back the shared pin
        chip_enable_i <= 1'b0;
        for (int p = 1; p >= 0; p--) begin
            b = p[0];
            for (int i = 0; i < 10; i++) wr(addrs[i], {16{b}} | keeps[i]);
            for (int i = 0; i < 10; i++) rd_chk(addrs[i], (({16{b}} |
                keeps[i]) & msks[i]) | (i == 7 ? FIX_BIAS : 16'h0000));
            check({dec, pas, acor, fmt, thr, hold, fuse, synb, spin, drv,
                rng[1], term, oclk, spoa, obuf, spob, pins, refs, refx,
                syncm, slp}, {46{b}});
            check({perf1, rng[0]}, 2'b11);
        end
        chip_enable_i <= 1'b1;
        wr(REG_TEMP, 16'hffff);
        rd_chk(REG_TEMP, 16'h01a5);
        wr(7'h10, 16'hffff);
        rd_chk(REG_SYNL, 16'h0000);
        // each sync mode and every reference code
        for (int i = 0; i < 8; i++) begin
            wr(REG_SYNH, {pats[i % 4], 5'h00, 3'(i), 4'h0});
            check({syncm, refs, refx}, {2'(i % 4), 3'(i), 1'(i > 4)});
        end
        // level equal to threshold must not trip, one above must
        wr(REG_OVR, 16'h0280);
        level_i <= 4'h5;
        repeat (20) @(posedge clock_i);
        #1 check(ovf, 1'b0);
        @(posedge clock_i);
        level_i <= 4'h6;
        repeat (12) @(posedge clock_i);
        #1 check(ovf, 1'b0);
        @(posedge clock_i);
        #1 check(ovf, 1'b1);
        @(posedge clock_i);
        level_i <= 4'h0;
        // a near-miss key must not reset anything
        wr(REG_SWR, 16'hd2f1);
        rd_chk(REG_OVR, 16'h0280);
        wr(REG_SWR, SWR_KEY);
        rd_chk(REG_SWR, 16'h0000);
        rd_chk(REG_OVR, RST_OVR);
        rd_chk(REG_DRV, RST_DRV);
        // hardware reset pin restores defaults as well
        wr(REG_OVR, 16'h0100);
        reset_pin_n_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        reset_pin_n_i <= 1'b1;
        repeat (8) @(posedge clock_i);
        rd_chk(REG_OVR, RST_OVR);
        tally_and_finish();
    end
endmodule
`default_nettype wire
